// ==== pkg/rtcs_consts.vh ====
// constants for the rtc square wave and event interrupt block
`ifndef RTCS_CONSTS_VH
`define RTCS_CONSTS_VH

// register indices; byte address is four times the index
`define RTCS_IDX_CTRL        10'h017
`define RTCS_IDX_STATUS      10'h019
`define RTCS_IDX_MASK        10'h021
`define RTCS_IDX_TRIM        10'h0da

// control register fields
`define RTCS_SQW_LSB         0
`define RTCS_SQW_MSB         3
`define RTCS_PER_LSB         4
`define RTCS_PER_MSB         6
`define RTCS_CTRL_RESET      16'h0020

// status and mask bit positions
`define RTCS_BIT_PER         7
`define RTCS_BIT_SEC         6
`define RTCS_BIT_ALM         5
`define RTCS_MASK_RESET      3'h0

// trim register fields
`define RTCS_TRIM_MSB        9
`define RTCS_TRIM_RESET      10'h000

// periodic interval codes
`define RTCS_PER_OFF         3'h0
`define RTCS_PER_SEC         3'h1
`define RTCS_PER_MIN         3'h2
`define RTCS_PER_HOUR        3'h3
`define RTCS_PER_DAY         3'h4
`define RTCS_PER_MONTH       3'h5

// counting figures
`define RTCS_OSC_LAST        15'h7fff
`define RTCS_SEC_LAST        6'h3b
`define RTCS_MIN_LAST        6'h3b
`define RTCS_HOUR_LAST       5'h17

`endif

// ==== hdl/rtcs_tick_gen.v ====
// trimmed one-second tick generator driven by the 32.768 khz enable
`timescale 1ns/1ps
`include "rtcs_consts.vh"

module rtcs_tick_gen
(
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        osc_tick_en,
    input  wire [9:0]  trim_val,
    output wire [14:0] div_cnt,
    output reg         sec_tick
);

    reg  [14:0] cnt_q;
    reg  [14:0] wrap_q;
    reg  [3:0]  stall_q;
    reg  [5:0]  frac_q;

    // fraction accumulates so that sub-hertz trim spreads over seconds
    wire [6:0]  frac_sum = {1'b0, frac_q} + {1'b0, trim_val[5:0]};
    wire [4:0]  adj      = {trim_val[9], trim_val[9:6]} + {4'h0, frac_sum[6]};
    wire [4:0]  adj_neg  = 5'h00 - adj;

    assign div_cnt = cnt_q;

    // extra cycles sit at count zero, so only the low phase stretches;
    // a short second wraps early, so only the high phase shrinks
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_q    <= 15'h0000;
            wrap_q   <= `RTCS_OSC_LAST;
            stall_q  <= 4'h0;
            frac_q   <= 6'h00;
            sec_tick <= 1'b0;
        end
        else
        begin
            sec_tick <= 1'b0;
            if (osc_tick_en)
            begin
                if (stall_q != 4'h0)
                begin
                    stall_q <= stall_q - 4'h1;
                end
                else if (cnt_q == wrap_q)
                begin
                    cnt_q    <= 15'h0000;
                    sec_tick <= 1'b1;
                    frac_q   <= frac_sum[5:0];
                    if (adj[4])
                    begin
                        stall_q <= 4'h0;
                        wrap_q  <= `RTCS_OSC_LAST - {11'h000, adj_neg[3:0]};
                    end
                    else
                    begin
                        stall_q <= adj[3:0];
                        wrap_q  <= `RTCS_OSC_LAST;
                    end
                end
                else
                begin
                    cnt_q <= cnt_q + 15'h0001;
                end
            end
        end
    end

endmodule

// ==== hdl/rtcs_top.v ====
// rtc square wave output and event interrupt block with apb registers
`timescale 1ns/1ps
`include "rtcs_consts.vh"

// Overview of operation
// - the square wave reaches the pin only while the pin is muxed to this function.
// - the square wave comes from the trimmed counter and spans 1 hz to 16.384 khz.
// - rate code zero turns the output off and codes 1 to 15 double from 1 hz to 16384 hz.
// - trim may shorten the high or lengthen the low time by up to 8 oscillator cycles.
// - one interrupt output gathers the periodic, seconds and alarm events.
// - the seconds flag is set on every one-second rollover.
// - the periodic rate selects off, second, minute, hour, day, month, with 11x off.
// - each periodic pulse lasts exactly one oscillator period.
// - the periodic pulse is held off while the set-time status is high.
// - the alarm flag is set whenever the alarm function signals.
// - flags set on rising edges: periodic bit 7, seconds bit 6, alarm bit 5.
// - a status read clears only the event flags already set at its setup; a flag raised later stays.
// - mask bits 7 to 5 mask the flag at the same position and reset to unmasked.
// - a signed 10-bit trim, msb weight -8 hz, adjusts the tick generator count.
module rtcs_top
(
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        osc_tick_en,
    input  wire        set_time_busy,
    input  wire        alarm_in,
    input  wire        month_rollover,
    input  wire        pin_func_sel,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         square_wave_pin,
    output reg         rtc_irq
);

    // software state
    reg  [3:0]  sqw_sel_q;
    reg  [2:0]  per_sel_q;
    reg  [2:0]  mask_q;
    reg  [9:0]  trim_q;
    reg  [2:0]  status_q;
    reg  [2:0]  status_d;
    reg  [2:0]  rd_clr_q;

    // time keeping state
    reg  [5:0]  sec_cnt_q;
    reg  [5:0]  min_cnt_q;
    reg  [4:0]  hour_cnt_q;
    reg         sec_level_q;
    reg         per_level_q;
    reg         sec_prev_q;
    reg         per_prev_q;
    reg         alm_prev_q;
    reg         osc_dly_q;

    // tick generator outputs
    wire [14:0] div_cnt;
    wire        sec_tick;

    // one decode function serves both the read and the write path
    function [1:0] reg_hit;
        input [11:0] addr;
        begin
            if (addr[1:0] != 2'b00)
                reg_hit = 2'd0;
            else if (addr[11:2] == `RTCS_IDX_CTRL)
                reg_hit = 2'd1;
            else if (addr[11:2] == `RTCS_IDX_MASK)
                reg_hit = 2'd2;
            else if (addr[11:2] == `RTCS_IDX_TRIM)
                reg_hit = 2'd3;
            else
                reg_hit = 2'd0;
        end
    endfunction

    // status stands apart: it may be read but never written
    function is_status;
        input [11:0] addr;
        begin
            is_status = (addr[1:0] == 2'b00) && (addr[11:2] == `RTCS_IDX_STATUS);
        end
    endfunction

    // apb phase decodes
    wire        setup_ph  = psel && !penable;
    wire        done_ph   = psel && penable && pready;
    wire        wr_done   = done_ph && pwrite && !pslverr;
    wire [1:0]  hit       = reg_hit(paddr);
    wire        stat_hit  = is_status(paddr);
    wire        bad_acc   = (hit == 2'd0) && !(stat_hit && !pwrite);

    // reset image of the control register, cut into its two fields below
    wire [15:0] ctrl_rst_val = `RTCS_CTRL_RESET;

    // trimmed tick generator; its counter also drives the square wave
    rtcs_tick_gen u_tick
    (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .osc_tick_en (osc_tick_en),
        .trim_val    (trim_q),
        .div_cnt     (div_cnt),
        .sec_tick    (sec_tick)
    );

    // calendar-style counters give the minute, hour and day rollovers;
    // they start at zero on reset and only serve as event strobes
    wire        min_roll  = sec_tick && (sec_cnt_q == `RTCS_SEC_LAST);
    wire        hour_roll = min_roll && (min_cnt_q == `RTCS_MIN_LAST);
    wire        day_roll  = hour_roll && (hour_cnt_q == `RTCS_HOUR_LAST);

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            sec_cnt_q  <= 6'h00;
            min_cnt_q  <= 6'h00;
            hour_cnt_q <= 5'h00;
        end
        else if (sec_tick)
        begin
            sec_cnt_q <= min_roll ? 6'h00 : sec_cnt_q + 6'h01;
            if (min_roll)
                min_cnt_q <= hour_roll ? 6'h00 : min_cnt_q + 6'h01;
            if (hour_roll)
                hour_cnt_q <= day_roll ? 5'h00 : hour_cnt_q + 5'h01;
        end
    end

    // periodic source selection; month length is the calendar's business
    // codes 0, 6 and 7 select nothing and leave the periodic level idle
    reg per_fire;
    always @*
    begin
        case (per_sel_q)
            `RTCS_PER_SEC:   per_fire = sec_tick;
            `RTCS_PER_MIN:   per_fire = min_roll;
            `RTCS_PER_HOUR:  per_fire = hour_roll;
            `RTCS_PER_DAY:   per_fire = day_roll;
            `RTCS_PER_MONTH: per_fire = month_rollover;
            default:         per_fire = 1'b0;
        endcase
    end

    // the tick and its rollovers appear in the cycle after an oscillator
    // enable, so the enable is delayed by one cycle to find the end of
    // that oscillator period; without it a level would be one cycle short
    always @(posedge clk_sys)
    begin
        if (rst)
            osc_dly_q <= 1'b0;
        else
            osc_dly_q <= osc_tick_en;
    end

    // seconds level rises with the tick and falls a full oscillator period later
    always @(posedge clk_sys)
    begin
        if (rst)
            sec_level_q <= 1'b0;
        else if (sec_tick)
            sec_level_q <= 1'b1;
        else if (osc_dly_q)
            sec_level_q <= 1'b0;
    end

    // periodic level, one oscillator period long; a time set in progress
    // beats every source, so a half-written time never raises an event
    always @(posedge clk_sys)
    begin
        if (rst)
            per_level_q <= 1'b0;
        else if (set_time_busy)
            per_level_q <= 1'b0;
        else if (per_fire)
            per_level_q <= 1'b1;
        else if (osc_dly_q)
            per_level_q <= 1'b0;
    end

    // rising edge detectors feeding the sticky flags; they reset low,
    // the idle level of every source, so reset itself makes no edge
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            sec_prev_q <= 1'b0;
            per_prev_q <= 1'b0;
            alm_prev_q <= 1'b0;
        end
        else
        begin
            sec_prev_q <= sec_level_q;
            per_prev_q <= per_level_q;
            alm_prev_q <= alarm_in;
        end
    end

    // one-cycle rising edges of the three event sources
    wire [2:0] ev_rise;
    assign ev_rise[2] = per_level_q && !per_prev_q;
    assign ev_rise[1] = sec_level_q && !sec_prev_q;
    assign ev_rise[0] = alarm_in && !alm_prev_q;

    // only bits seen by the read are cleared; a new set always wins
    // a flag raised between setup and access stays for the next read
    always @*
    begin
        status_d = status_q;
        if (done_ph && !pwrite && stat_hit)
            status_d = status_d & ~rd_clr_q;
        status_d = status_d | ev_rise;
    end

    // flags, mask and registered interrupt
    // irq is built from the next flag value so it rises with the flag
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            status_q <= 3'h0;
            rtc_irq  <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            rtc_irq  <= |(status_d & ~mask_q);
        end
    end

    // software registers change at the completing access edge only
    // refused accesses never reach here, since wr_done excludes pslverr
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            sqw_sel_q <= ctrl_rst_val[`RTCS_SQW_MSB:`RTCS_SQW_LSB];
            per_sel_q <= ctrl_rst_val[`RTCS_PER_MSB:`RTCS_PER_LSB];
            mask_q    <= `RTCS_MASK_RESET;
            trim_q    <= `RTCS_TRIM_RESET;
        end
        else if (wr_done)
        begin
            if (hit == 2'd1)
            begin
                sqw_sel_q <= pwdata[`RTCS_SQW_MSB:`RTCS_SQW_LSB];
                per_sel_q <= pwdata[`RTCS_PER_MSB:`RTCS_PER_LSB];
            end
            else if (hit == 2'd2)
                mask_q <= pwdata[`RTCS_BIT_PER:`RTCS_BIT_ALM];
            else if (hit == 2'd3)
                trim_q <= pwdata[`RTCS_TRIM_MSB:0];
        end
    end

    // read data are chosen from the state at the setup edge; a write
    // and a refused address both read back as zero
    reg  [31:0] rd_mux_d;
    always @*
    begin
        if (pwrite)
            rd_mux_d = 32'h00000000;
        else if (stat_hit)
            rd_mux_d = {24'h000000, status_q, 5'h00};
        else if (hit == 2'd1)
            rd_mux_d = {25'h0000000, per_sel_q, sqw_sel_q};
        else if (hit == 2'd2)
            rd_mux_d = {24'h000000, mask_q, 5'h00};
        else if (hit == 2'd3)
            rd_mux_d = {22'h000000, trim_q};
        else
            rd_mux_d = 32'h00000000;
    end

    // apb slave: data latched in setup, no wait state, pready high in the first access cycle
    // pready always follows setup by one cycle, so the access has no waits
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            rd_clr_q <= 3'h0;
        end
        else if (setup_ph)
        begin
            pready   <= 1'b1;
            pslverr  <= bad_acc;
            rd_clr_q <= status_q;
            prdata   <= rd_mux_d;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // square wave: counter bit 15-n gives 2^(n-1) hz at 50 percent duty;
    // the trim stall holds the counter at zero, so it stretches the low phase
    reg        sqw_raw;
    always @*
    begin
        case (sqw_sel_q)
            4'h1:    sqw_raw = div_cnt[14];
            4'h2:    sqw_raw = div_cnt[13];
            4'h3:    sqw_raw = div_cnt[12];
            4'h4:    sqw_raw = div_cnt[11];
            4'h5:    sqw_raw = div_cnt[10];
            4'h6:    sqw_raw = div_cnt[9];
            4'h7:    sqw_raw = div_cnt[8];
            4'h8:    sqw_raw = div_cnt[7];
            4'h9:    sqw_raw = div_cnt[6];
            4'ha:    sqw_raw = div_cnt[5];
            4'hb:    sqw_raw = div_cnt[4];
            4'hc:    sqw_raw = div_cnt[3];
            4'hd:    sqw_raw = div_cnt[2];
            4'he:    sqw_raw = div_cnt[1];
            4'hf:    sqw_raw = div_cnt[0];
            default: sqw_raw = 1'b0;
        endcase
    end

    // pin output rests low while unmuxed or off, so the pad sees no stray edge
    always @(posedge clk_sys)
    begin
        if (rst)
            square_wave_pin <= 1'b0;
        else if (sqw_sel_q == 4'h0)
            square_wave_pin <= 1'b0;
        else
            square_wave_pin <= pin_func_sel && sqw_raw;
    end

endmodule

// ==== tb/rtcs_pin_model.sv ====
// pin partner: measures clock cycles between edges of the square wave pin
`timescale 1ns/1ps
module rtcs_pin_model
(
    input  wire        clk_sys,
    input  wire        pin,
    output reg  [15:0] half_len
);
    reg [15:0] cnt_q;
    reg        pin_q;

    // restart the count at each edge; only the last full half period is kept
    always @(posedge clk_sys)
    begin
        pin_q <= pin;
        cnt_q <= (pin != pin_q) ? 16'h0001 : cnt_q + 16'h0001;
        if (pin != pin_q)
            half_len <= cnt_q;
    end
endmodule

// ==== tb/rtcs_chk_properties.sv ====
// assertion checker for the rtc square wave and event interrupt block
`timescale 1ns/1ps
module rtcs_chk
(
    input wire        clk_sys,
    input wire        rst,
    input wire        alarm_in,
    input wire        month_rollover,
    input wire        set_time_busy,
    input wire        pin_func_sel,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        square_wave_pin,
    input wire        rtc_irq
);
    reg  [3:0] sqw_q;
    reg  [2:0] per_q;
    reg  [2:0] msk_q;
    wire       wr_go = psel && penable && pready && pwrite;
    wire       rd_st = psel && penable && pready && !pwrite && paddr == 12'h064;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // shadow of control and mask fields, since the checker cannot see the registers
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            sqw_q <= 4'h0;
            per_q <= 3'h2;
            msk_q <= 3'h0;
        end
        else if (wr_go && paddr == 12'h05c)
        begin
            sqw_q <= pwdata[3:0];
            per_q <= pwdata[6:4];
        end
        else if (wr_go && paddr == 12'h084)
            msk_q <= pwdata[7:5];
    end

    chk_pin_unmuxed: assert property (
        !pin_func_sel && !$past(pin_func_sel) |-> !square_wave_pin)
        else $error("pin driven while unmuxed");
    chk_rate_off: assert property (
        sqw_q == 4'h0 && $past(sqw_q) == 4'h0 |-> !square_wave_pin)
        else $error("pin driven with rate code zero");
    chk_alarm_irq: assert property (
        $rose(alarm_in) && !msk_q[0] |-> ##[1:4] rtc_irq)
        else $error("alarm edge gave no interrupt");
    chk_month_irq: assert property (
        month_rollover && per_q == 3'h5 && !set_time_busy && !msk_q[2] |-> ##[1:6] rtc_irq)
        else $error("month event gave no interrupt");
    chk_busy_blocks: assert property (
        month_rollover && set_time_busy && msk_q[1] && !rtc_irq |=> !rtc_irq [*6])
        else $error("periodic event while time set busy");
    chk_read_clears: assert property (
        rd_st |=> !rtc_irq)
        else $error("interrupt stayed after status read");
    chk_mask_all: assert property (
        msk_q == 3'h7 && $past(msk_q) == 3'h7 |-> !rtc_irq)
        else $error("interrupt with all events masked");
    chk_status_wr: assert property (
        wr_go && paddr == 12'h064 |-> pslverr)
        else $error("status write not refused");
endmodule

bind rtcs_top rtcs_chk u_chk (.clk_sys(clk_sys), .rst(rst), .alarm_in(alarm_in),
    .month_rollover(month_rollover), .set_time_busy(set_time_busy),
    .pin_func_sel(pin_func_sel), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .square_wave_pin(square_wave_pin), .rtc_irq(rtc_irq));

// ==== tb/rtcs_top_test.sv ====
// self-checking bench for the rtc square wave and event interrupt block
`timescale 1ns/1ps
module rtcs_top_test;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg         osc_tick_en = 1'b1;
    reg         set_time_busy = 1'b0, alarm_in = 1'b0, month_rollover = 1'b0;
    reg         pin_func_sel = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, square_wave_pin, rtc_irq;
    wire [15:0] half_len;
    reg  [31:0] rd;
    reg         err;
    integer     n_fail = 0, num_checks = 0, cyc = 0, i;

    rtcs_top DUT (.clk_sys(clk_sys), .rst(rst), .osc_tick_en(osc_tick_en),
        .set_time_busy(set_time_busy), .alarm_in(alarm_in), .month_rollover(month_rollover),
        .pin_func_sel(pin_func_sel), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .square_wave_pin(square_wave_pin), .rtc_irq(rtc_irq));
    rtcs_pin_model u_pin (.clk_sys(clk_sys), .pin(square_wave_pin), .half_len(half_len));

    // 40 mhz system clock; osc tick every cycle makes one second 32768 cycles
    always #12.5 clk_sys = ~clk_sys;

    // the run needs about 50000 cycles, so a hang is cut at 60000
    always @(posedge clk_sys)
    begin
        cyc = cyc + 1;
        if (cyc == 60000)
        begin
            n_fail = n_fail + 1;
            final_report;
        end
    end

    task final_report;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    task check(input [31:0] seen, input [31:0] exp, input [95:0] what);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask

    task wait_clk(input integer n);
    begin
        repeat (n) @(posedge clk_sys);
    end
    endtask

    // one apb transfer; request held until pready is seen high
    task apb(input wr, input [11:0] a, input [31:0] d);
    begin
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task rd_chk(input [11:0] a, input [31:0] m, input [31:0] exp, input [95:0] what);
    begin
        apb(1'b0, a, 32'h0);
        check(rd & m, exp, what);
    end
    endtask

    task month_pulse;
    begin
        @(posedge clk_sys);
        month_rollover <= 1'b1;
        @(posedge clk_sys);
        month_rollover <= 1'b0;
        wait_clk(10);
    end
    endtask

    initial
    begin
        wait_clk(5);
        rst <= 1'b0;
        rd_chk(12'h05c, 32'hffffffff, 32'h20, "ctrl_rst");
        rd_chk(12'h084, 32'hffffffff, 32'h0, "mask_rst");
        rd_chk(12'h064, 32'hffffffff, 32'h0, "stat_rst");
        apb(1'b0, 12'h100, 32'h0);
        check(32'(err), 32'h1, "unmap_err");
        apb(1'b1, 12'h064, 32'hffff);
        check(32'(err), 32'h1, "stat_wr_err");
        apb(1'b1, 12'h368, 32'h3c0);
        rd_chk(12'h368, 32'hffffffff, 32'h3c0, "trim");
        apb(1'b1, 12'h368, 32'h0);
        $display("test registers done");
        // square wave: silent while unmuxed, then the fast rates
        apb(1'b1, 12'h05c, 32'h2f);
        wait_clk(40);
        check(32'(square_wave_pin), 32'h0, "pin_unsel");
        pin_func_sel <= 1'b1;
        for (i = 10; i < 16; i = i + 1)
        begin
            apb(1'b1, 12'h05c, 32'h20 | i);
            wait_clk(120);
            check(32'(half_len), 32'h1 << (15 - i), "half_len");
        end
        apb(1'b1, 12'h05c, 32'h20);
        wait_clk(5);
        check(32'(square_wave_pin), 32'h0, "pin_off");
        $display("test square wave done");
        // seconds masked so a rollover cannot disturb event checks
        apb(1'b1, 12'h084, 32'h40);
        for (i = 0; i < 8; i = i + 1)
            if (i != 1)
            begin
                apb(1'b1, 12'h05c, i << 4);
                apb(1'b0, 12'h064, 32'h0);
                month_pulse;
                rd_chk(12'h064, 32'h80, (i == 5) ? 32'h80 : 32'h0, "per_code");
            end
        apb(1'b1, 12'h05c, 32'h50);
        set_time_busy <= 1'b1;
        month_pulse;
        rd_chk(12'h064, 32'h80, 32'h0, "per_busy");
        set_time_busy <= 1'b0;
        @(posedge clk_sys);
        alarm_in <= 1'b1;
        wait_clk(8);
        check(32'(rtc_irq), 32'h1, "irq_alarm");
        rd_chk(12'h064, 32'ha0, 32'h20, "alarm_flag");
        wait_clk(2);
        check(32'(rtc_irq), 32'h0, "irq_cleared");
        rd_chk(12'h064, 32'ha0, 32'h0, "alarm_level");
        alarm_in <= 1'b0;
        apb(1'b1, 12'h084, 32'he0);
        rd_chk(12'h084, 32'hffff, 32'he0, "mask_rw");
        alarm_in <= 1'b1;
        wait_clk(8);
        check(32'(rtc_irq), 32'h0, "irq_masked");
        rd_chk(12'h064, 32'h20, 32'h20, "flag_masked");
        alarm_in <= 1'b0;
        $display("test events done");
        // a full second with periodic set to one second and a 1 hz wave
        apb(1'b1, 12'h084, 32'h0);
        apb(1'b1, 12'h05c, 32'h11);
        apb(1'b1, 12'h368, 32'h80); // +2 hz trim, taken at the coming rollover
        apb(1'b0, 12'h064, 32'h0);
        wait_clk(33000);
        check(32'(half_len), 32'h4000, "half_1hz");
        check(32'(rtc_irq), 32'h1, "irq_sec");
        rd_chk(12'h064, 32'he0, 32'hc0, "sec_per");
        wait_clk(2);
        check(32'(rtc_irq), 32'h0, "irq_read");
        // the stalled counter stretches the next low phase by two cycles
        wait_clk(16000);
        check(32'(half_len), 32'h4002, "half_trim");
        $display("test seconds done");
        final_report;
    end
endmodule
